// ### hw/sdmc_consts.vh
// Register map, field positions and reset values of the converter control
`ifndef SDMC_CONSTS_VH
`define SDMC_CONSTS_VH

// Register offsets on the byte register port
`define SDMC_ADDR_W 4
`define SDMC_OFF_CTL_ZERO 4'h0
`define SDMC_OFF_CTL_ONE 4'h1
`define SDMC_OFF_CLK_SETUP 4'h2
`define SDMC_OFF_CHAN_SETUP 4'h3
`define SDMC_OFF_RES_LOW 4'h4
`define SDMC_OFF_RES_MID 4'h5
`define SDMC_OFF_RES_HIGH 4'h6
`define SDMC_OFF_INT_CTL 4'h7
`define SDMC_OFF_PWR_CTL 4'h8

// converter_control_zero fields
`define SDMC_BIT_FRST 7
`define SDMC_BIT_SLEEP 6
`define SDMC_BIT_POFF 5
`define SDMC_OSR_HI 4
`define SDMC_OSR_LO 2
`define SDMC_BIT_REFSEL 0
`define SDMC_CTL_ZERO_RST 8'h20

// amplifier_channel_setup fields
`define SDMC_CHANP_HI 3
`define SDMC_CHANN_HI 7
`define SDMC_CHANN_LO 4

// converter_control_one fields
`define SDMC_CHOP_HI 7
`define SDMC_CHOP_LO 5
`define SDMC_BIT_HOLD 2
`define SDMC_BIT_DONE 1

// Chop/clock code bits: bit 2 drops doubling, bit 1 picks the fast clock
`define SDMC_CHOP_SINGLE_BIT 2
`define SDMC_CHOP_FAST_BIT 1
`define SDMC_ADCK_DIV_SLOW 5'd30
`define SDMC_ADCK_DIV_FAST 5'd12

// converter_clock_setup field
`define SDMC_CKDIV_HI 4
`define SDMC_CKDIV_BYPASS 5'h1f

// Interrupt control and power control fields
`define SDMC_BIT_GIE 0
`define SDMC_BIT_CIE 1
`define SDMC_BIT_IREQ 2
`define SDMC_BIT_REGEN 0

// Filter sizing
`define SDMC_OSR_BASE 16'h4000
`define SDMC_SHIFT_BASE 5'd9
`define SDMC_RESULT_W 24
`define SDMC_POS_FULL 32'sh007f_ffff
`define SDMC_NEG_FULL -32'sh0080_0000
`define SDMC_RES_MAX 24'h7f_ffff
`define SDMC_RES_MIN 24'h80_0000

// Channel code that routes the temperature sensor
`define SDMC_TEMP_CHAN 4'hf

`endif

// ### hw/sdmc_clk_div.v
// Master clock divider: one enable tick per master clock period
`timescale 1ns/100ps
`default_nettype none
`include "sdmc_consts.vh"

module sdmc_clk_div (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Divider code and tick
  input wire [4:0] div_code,
  output wire mclk_tick
);

  reg [5:0] cnt_reg;
  reg [5:0] cnt_next;
  wire [5:0] last_count;
  wire bypass;

  // Period is two times (code plus one) system cycles
  assign last_count = {div_code, 1'b1};
  assign bypass = (div_code == `SDMC_CKDIV_BYPASS);
  assign mclk_tick = bypass | (cnt_reg >= last_count);

  always @* begin
    if (mclk_tick) begin
      cnt_next = 6'h00;
    end else begin
      cnt_next = cnt_reg + 6'h01;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 6'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule
`default_nettype wire

// ### hw/sdmc_mode_control.v
// Mode selection, decimation filter and registers of the converter
`timescale 1ns/100ps
`default_nettype none
`include "sdmc_consts.vh"
// Notes on behaviour
// (R1) Four modes from off, sleep, reset bits
// (R2) Power-off stops amplifier, modulator, sensor, filter
// (R3) Common-mode generator follows bandgap enable
// (R4) Sleep stops modulator and sensor only
// (R5) Filter-reset bit holds filter in reset
// (R6) Falling filter-reset edge starts new conversion
// (R7) Software powers up before pulsing reset
// (R8) Conversion end sets done flag
// (R9) Conversion end sets interrupt request
// (R10) Interrupt needs global and converter enables
// (R11) Without hold, each result overwrites registers
// (R12) With hold, result kept, later discarded
// (R13) Held: no request, done flag unchanged
// (R14) Done flag cleared only by writing zero
// (R15) Master clock divided from system clock
// (R16) Divide by 2(code+1); all-ones bypasses
// (R17) Reference select picks common-mode or regulator
// (R18) Data rate from oversampling and chop fields
// (R19) Oversampling codes give 16384 down to 128
// (R20) Amplifier inputs follow channel fields
// (R21) Sensor on only when selected, normal/reset
// (R22) Filter restarts empty, full cycle first

module sdmc_mode_control #(
  parameter [3:0] TEMP_POS_CODE = `SDMC_TEMP_CHAN,
  parameter [3:0] TEMP_NEG_CODE = `SDMC_TEMP_CHAN
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Register port
  input wire [`SDMC_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Modulator bitstream
  input wire mod_bit,
  // Analogue enables
  output wire bandgap_en,
  output wire cm_ref_en,
  output wire regulator_on,
  output wire amp_en,
  output wire modulator_en,
  output wire temp_sensor_en,
  output wire filter_en,
  output wire filter_in_reset,
  // Analogue selections
  output wire reference_pair_select,
  output wire [3:0] positive_channel_select,
  output wire [3:0] negative_channel_select,
  output wire [2:0] oversampling_rate_select,
  output wire [2:0] chop_clock_select,
  // Clocks and events
  output wire mclk_tick,
  output wire sample_tick,
  output wire conv_irq
);

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  function hit;
    input [`SDMC_ADDR_W-1:0] addr;
    input [`SDMC_ADDR_W-1:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // Scale the sample sum to 24 bits and clamp at full scale
  function [`SDMC_RESULT_W-1:0] scale_sum;
    input [17:0] sum;
    input [4:0] shift;
    reg signed [31:0] wide;
    begin
      wide = $signed({{14{sum[17]}}, sum}) <<< shift;
      if (wide > `SDMC_POS_FULL) begin
        scale_sum = `SDMC_RES_MAX;
      end else if (wide < `SDMC_NEG_FULL) begin
        scale_sum = `SDMC_RES_MIN;
      end else begin
        scale_sum = wide[`SDMC_RESULT_W-1:0];
      end
    end
  endfunction

  // Reset release through two flops
  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_n;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // Software registers
  reg frst_reg;
  reg sleep_reg;
  reg poff_reg;
  reg [2:0] osr_reg;
  reg refsel_reg;
  reg [2:0] chop_reg;
  reg hold_reg;
  reg done_reg;
  reg [4:0] ckdiv_reg;
  reg [3:0] chan_pos_reg;
  reg [3:0] chan_neg_reg;
  reg gie_reg;
  reg cie_reg;
  reg ireq_reg;
  reg regen_reg;
  reg [`SDMC_RESULT_W-1:0] result_reg;
  reg done_next;
  reg ireq_next;

  // Filter state
  reg state_reg;
  reg frst_prev_reg;
  reg [4:0] adck_cnt_reg;
  reg [15:0] samp_cnt_reg;
  reg [16:0] acc_reg;
  reg conv_end_reg;
  reg [`SDMC_RESULT_W-1:0] conv_val_reg;

  wire wr_ctl0;
  wire wr_ctl1;
  wire wr_int;
  wire sensor_selected;
  wire start_pulse;
  wire [4:0] adck_last;
  wire chop_double;
  wire [15:0] n_samples;
  wire [4:0] shift;
  wire [17:0] final_sum;
  wire conv_done;

  assign wr_ctl0 = reg_wr & hit(reg_addr, `SDMC_OFF_CTL_ZERO);
  assign wr_ctl1 = reg_wr & hit(reg_addr, `SDMC_OFF_CTL_ONE);
  assign wr_int = reg_wr & hit(reg_addr, `SDMC_OFF_INT_CTL);

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      frst_reg <= 1'b0;
      sleep_reg <= 1'b0;
      poff_reg <= 1'b1;
      osr_reg <= 3'h0;
      refsel_reg <= 1'b0;
      chop_reg <= 3'h0;
      hold_reg <= 1'b0;
      ckdiv_reg <= 5'h00;
      chan_pos_reg <= 4'h0;
      chan_neg_reg <= 4'h0;
      gie_reg <= 1'b0;
      cie_reg <= 1'b0;
      regen_reg <= 1'b0;
    end else begin
      if (wr_ctl0) begin
        frst_reg <= reg_wdata[`SDMC_BIT_FRST];
        sleep_reg <= reg_wdata[`SDMC_BIT_SLEEP];
        poff_reg <= reg_wdata[`SDMC_BIT_POFF];
        osr_reg <= reg_wdata[`SDMC_OSR_HI:`SDMC_OSR_LO];
        refsel_reg <= reg_wdata[`SDMC_BIT_REFSEL];
      end
      if (wr_ctl1) begin
        chop_reg <= reg_wdata[`SDMC_CHOP_HI:`SDMC_CHOP_LO];
        hold_reg <= reg_wdata[`SDMC_BIT_HOLD];
      end
      if (reg_wr & hit(reg_addr, `SDMC_OFF_CLK_SETUP)) begin
        ckdiv_reg <= reg_wdata[`SDMC_CKDIV_HI:0];
      end
      if (reg_wr & hit(reg_addr, `SDMC_OFF_CHAN_SETUP)) begin
        chan_pos_reg <= reg_wdata[`SDMC_CHANP_HI:0];
        chan_neg_reg <= reg_wdata[`SDMC_CHANN_HI:`SDMC_CHANN_LO];
      end
      if (wr_int) begin
        gie_reg <= reg_wdata[`SDMC_BIT_GIE];
        cie_reg <= reg_wdata[`SDMC_BIT_CIE];
      end
      if (reg_wr & hit(reg_addr, `SDMC_OFF_PWR_CTL)) begin
        regen_reg <= reg_wdata[`SDMC_BIT_REGEN];
      end
    end
  end

  // (R1) mode decode
  // (R2) power-off overrides sleep and reset
  assign amp_en = ~poff_reg;
  assign filter_en = ~poff_reg;
  // (R4) sleep stops modulator
  assign modulator_en = ~poff_reg & ~sleep_reg;
  // (R5) filter reset hold
  assign filter_in_reset = ~poff_reg & ~sleep_reg & frst_reg;
  assign bandgap_en = regen_reg | ~poff_reg;
  // (R3) follows bandgap
  assign cm_ref_en = bandgap_en;
  assign regulator_on = regen_reg;

  // (R21) sensor only when selected
  assign sensor_selected = (chan_pos_reg == TEMP_POS_CODE) |
                           (chan_neg_reg == TEMP_NEG_CODE);
  assign temp_sensor_en = modulator_en & sensor_selected;

  // (R17) reference pair output
  assign reference_pair_select = refsel_reg;
  // (R20) amplifier routing
  assign positive_channel_select = chan_pos_reg;
  assign negative_channel_select = chan_neg_reg;
  assign oversampling_rate_select = osr_reg;
  assign chop_clock_select = chop_reg;

  // (R15) master clock from system clock
  // (R16) divider with bypass code
  sdmc_clk_div u_clk_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .div_code(ckdiv_reg),
    .mclk_tick(mclk_tick)
  );

  // (R18) sample clock from chop field
  assign adck_last = chop_reg[`SDMC_CHOP_FAST_BIT] ?
                     (`SDMC_ADCK_DIV_FAST - 5'd1) :
                     (`SDMC_ADCK_DIV_SLOW - 5'd1);
  assign sample_tick = mclk_tick & modulator_en &
                       (adck_cnt_reg >= adck_last);

  // (R19) ratio halves per code step
  // (R18) chop doubling lengthens the cycle
  assign chop_double = ~chop_reg[`SDMC_CHOP_SINGLE_BIT];
  assign n_samples = (`SDMC_OSR_BASE >> osr_reg) << chop_double;
  assign shift = `SDMC_SHIFT_BASE + {2'b00, osr_reg} -
                 {4'h0, chop_double};

  assign final_sum = {acc_reg[16], acc_reg} +
                     (mod_bit ? 18'h0_0001 : 18'h3_ffff);
  assign conv_done = (state_reg == ST_RUN) & sample_tick &
                     (samp_cnt_reg >= n_samples - 16'h0001);

  // (R6) start on falling filter-reset edge
  assign start_pulse = frst_prev_reg & ~frst_reg & ~poff_reg;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      frst_prev_reg <= 1'b0;
      adck_cnt_reg <= 5'h00;
      samp_cnt_reg <= 16'h0000;
      acc_reg <= 17'h0_0000;
      conv_end_reg <= 1'b0;
      conv_val_reg <= 24'h00_0000;
    end else begin
      frst_prev_reg <= frst_reg;
      conv_end_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          adck_cnt_reg <= 5'h00;
          samp_cnt_reg <= 16'h0000;
          acc_reg <= 17'h0_0000;
          // (R22) begin from empty filter
          if (start_pulse) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (poff_reg | frst_reg) begin
            state_reg <= ST_IDLE;
          end else if (mclk_tick & modulator_en) begin
            if (sample_tick) begin
              adck_cnt_reg <= 5'h00;
            end else begin
              adck_cnt_reg <= adck_cnt_reg + 5'h01;
            end
            if (conv_done) begin
              samp_cnt_reg <= 16'h0000;
              acc_reg <= 17'h0_0000;
              conv_end_reg <= 1'b1;
              conv_val_reg <= scale_sum(final_sum, shift);
            end else if (sample_tick) begin
              samp_cnt_reg <= samp_cnt_reg + 16'h0001;
              acc_reg <= final_sum[16:0];
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Event flags; a set in the clearing cycle wins
  always @* begin
    done_next = done_reg;
    ireq_next = ireq_reg;
    // (R14) only a zero write clears
    if (wr_ctl1 & ~reg_wdata[`SDMC_BIT_DONE]) begin
      done_next = 1'b0;
    end
    if (wr_int & ~reg_wdata[`SDMC_BIT_IREQ]) begin
      ireq_next = 1'b0;
    end
    // (R13) held results raise nothing
    if (conv_end_reg & ~hold_reg) begin
      // (R8) done flag set
      done_next = 1'b1;
      // (R9) request flag set
      ireq_next = 1'b1;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
      ireq_reg <= 1'b0;
      result_reg <= 24'h00_0000;
    end else begin
      done_reg <= done_next;
      ireq_reg <= ireq_next;
      // (R11) overwrite without waiting
      // (R12) hold discards new results
      if (conv_end_reg & ~hold_reg) begin
        result_reg <= conv_val_reg;
      end
    end
  end

  // (R10) both enables gate the request
  assign conv_irq = ireq_reg & gie_reg & cie_reg;

  // Read data stand only in the cycle after the strobe
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `SDMC_OFF_CTL_ZERO:
          reg_rdata <= {frst_reg, sleep_reg, poff_reg, osr_reg,
                        1'b0, refsel_reg};
        `SDMC_OFF_CTL_ONE:
          reg_rdata <= {chop_reg, 2'b00, hold_reg, done_reg, 1'b0};
        `SDMC_OFF_CLK_SETUP:
          reg_rdata <= {3'b000, ckdiv_reg};
        `SDMC_OFF_CHAN_SETUP:
          reg_rdata <= {chan_neg_reg, chan_pos_reg};
        `SDMC_OFF_RES_LOW:
          reg_rdata <= result_reg[7:0];
        `SDMC_OFF_RES_MID:
          reg_rdata <= result_reg[15:8];
        `SDMC_OFF_RES_HIGH:
          reg_rdata <= result_reg[23:16];
        `SDMC_OFF_INT_CTL:
          reg_rdata <= {5'b00000, ireq_reg, cie_reg, gie_reg};
        `SDMC_OFF_PWR_CTL:
          reg_rdata <= {7'b0000000, regen_reg};
        default:
          reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

// ### tb/sdmc_mode_control_props.sv
// Port-level checker for the converter mode control
`timescale 1ns/100ps
`default_nettype none
`include "sdmc_consts.vh"
module sdmc_mode_control_props #(
  parameter [3:0] TEMP_POS_CODE = `SDMC_TEMP_CHAN,
  parameter [3:0] TEMP_NEG_CODE = `SDMC_TEMP_CHAN
) (
  // Clock, reset and register port
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  // Enables and selections
  input wire logic bandgap_en,
  input wire logic cm_ref_en,
  input wire logic regulator_on,
  input wire logic amp_en,
  input wire logic modulator_en,
  input wire logic temp_sensor_en,
  input wire logic filter_in_reset,
  input wire logic [3:0] positive_channel_select,
  input wire logic [3:0] negative_channel_select,
  // Events
  input wire logic mclk_tick,
  input wire logic sample_tick,
  input wire logic conv_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_bypass_wr;
    reg_wr && reg_addr == `SDMC_OFF_CLK_SETUP && reg_wdata[4:0] == 5'h1f;
  endsequence
  sequence s_no_clk_wr;
    !(reg_wr && reg_addr == `SDMC_OFF_CLK_SETUP);
  endsequence
  a_poff_all_off: assert property (!amp_en |-> !modulator_en
    && !temp_sensor_en && !filter_in_reset) else $error("power off leak");
  a_cm_follows_bg: assert property (cm_ref_en == bandgap_en)
    else $error("common-mode differs from bandgap");
  a_bg_off_cause: assert property (!bandgap_en |-> !amp_en
    && !regulator_on) else $error("bandgap off while powered");
  a_sleep_stops: assert property (amp_en && !modulator_en
    |-> !temp_sensor_en && !filter_in_reset) else $error("sleep leak");
  a_frst_mode: assert property (filter_in_reset |-> amp_en
    && modulator_en) else $error("filter reset outside reset mode");
  a_temp_select: assert property (temp_sensor_en |-> modulator_en
    && (positive_channel_select == TEMP_POS_CODE
    || negative_channel_select == TEMP_NEG_CODE))
    else $error("sensor on unselected");
  a_irq_gated: assert property (reg_wr
    && reg_addr == `SDMC_OFF_INT_CTL && reg_wdata[1:0] != 2'b11
    |=> !conv_irq) else $error("interrupt without both enables");
  a_bypass_tick: assert property (s_bypass_wr ##1 s_no_clk_wr[*3]
    |-> mclk_tick) else $error("bypass code does not tick");
  a_sample_gate: assert property (sample_tick |-> modulator_en)
    else $error("sampling while modulator stopped");
  a_sample_on_tick: assert property (sample_tick |-> mclk_tick)
    else $error("sample outside master clock tick");
endmodule
bind sdmc_mode_control sdmc_mode_control_props #(
  .TEMP_POS_CODE(TEMP_POS_CODE), .TEMP_NEG_CODE(TEMP_NEG_CODE)
) i_props (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .bandgap_en(bandgap_en),
  .cm_ref_en(cm_ref_en), .regulator_on(regulator_on), .amp_en(amp_en),
  .modulator_en(modulator_en), .temp_sensor_en(temp_sensor_en),
  .filter_in_reset(filter_in_reset),
  .positive_channel_select(positive_channel_select),
  .negative_channel_select(negative_channel_select),
  .mclk_tick(mclk_tick), .sample_tick(sample_tick), .conv_irq(conv_irq));
`default_nettype wire

// ### tb/sdmc_mod_model.sv
// Behavioural modulator bitstream source
`timescale 1ns/100ps
`default_nettype none
module sdmc_mod_model (
  // Clock and sampling
  input wire logic core_clk,
  input wire logic sample_tick,
  input wire logic modulator_en,
  // 0 all minus, 1 all plus, else alternating
  input wire logic [1:0] pattern,
  output logic mod_bit
);
  initial mod_bit = 1'b0;
  // Stopped modulator gives a moving pattern, never a held value
  always @(posedge core_clk) begin
    if (!modulator_en) begin
      mod_bit <= ~mod_bit;
    end else if (pattern == 2'd0) begin
      mod_bit <= 1'b0;
    end else if (pattern == 2'd1) begin
      mod_bit <= 1'b1;
    end else if (sample_tick) begin
      mod_bit <= ~mod_bit;
    end
  end
endmodule
`default_nettype wire

// ### tb/sdmc_mode_control_tb.sv
// Self-checking bench of the converter mode control
`timescale 1ns/100ps
`default_nettype none
module sdmc_mode_control_tb;
  logic core_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, mod_bit;
  logic [3:0] reg_addr = 0, pos_ch, neg_ch;
  logic [7:0] reg_wdata = 0, reg_rdata, d, ch;
  logic [1:0] pattern = 1;
  logic bandgap_en, cm_ref_en, regulator_on, amp_en, modulator_en;
  logic temp_sensor_en, filter_en, filter_in_reset, reference_pair_select;
  logic [2:0] oversampling_rate_select, chop_clock_select, osr;
  logic mclk_tick, sample_tick, conv_irq, pw, bg, md;
  logic [23:0] res;
  int n_mismatch = 0, n_checks = 0, i, k, n;
  always #5 core_clk = ~core_clk;
  sdmc_mode_control i_dut (.core_clk(core_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mod_bit(mod_bit),
    .bandgap_en(bandgap_en), .cm_ref_en(cm_ref_en),
    .regulator_on(regulator_on), .amp_en(amp_en),
    .modulator_en(modulator_en), .temp_sensor_en(temp_sensor_en),
    .filter_en(filter_en), .filter_in_reset(filter_in_reset),
    .reference_pair_select(reference_pair_select),
    .positive_channel_select(pos_ch), .negative_channel_select(neg_ch),
    .oversampling_rate_select(oversampling_rate_select),
    .chop_clock_select(chop_clock_select), .mclk_tick(mclk_tick),
    .sample_tick(sample_tick), .conv_irq(conv_irq));
  sdmc_mod_model i_mod (.core_clk(core_clk), .sample_tick(sample_tick),
    .modulator_en(modulator_en), .pattern(pattern), .mod_bit(mod_bit));
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 0;
    #1 v = reg_rdata;
  endtask
  task automatic rd_res(output logic [23:0] r);
    logic [7:0] b;
    rd(6, b);
    r[23:16] = b;
    rd(5, b);
    r[15:8] = b;
    rd(4, b);
    r[7:0] = b;
  endtask
  task automatic wait_done;
    for (n = 0; n < 3000; n++) begin
      rd(1, d);
      if (d[1] === 1'b1) return;
    end
    n_mismatch++;
    test_done();
  endtask
  task automatic tick_gap(input logic [4:0] c);
    for (i = 0; i < 100 && mclk_tick !== 1'b1; i++) @(posedge core_clk) #1;
    for (k = 1; k < 100; k++) begin
      @(posedge core_clk) #1;
      if (mclk_tick === 1'b1) break;
    end
    // period of the master clock tick
    chk(k, (c == 5'h1f) ? 1 : 2 * (c + 1));
    if (i >= 100 || k >= 100) begin
      n_mismatch++;
      test_done();
    end
  endtask
  initial begin
    void'($urandom(32'h7e976ff1));
    repeat (2) @(posedge core_clk);
    rst_b <= 1;
    repeat (3) @(posedge core_clk);
    rd(0, d);
    chk(d, 8'h20);
    rd(1, d);
    chk(d, 0);
    rd(4'hf, d);
    chk(d, 0);
    chk({amp_en, filter_en, bandgap_en}, 0);
    for (int m = 0; m < 16; m++) begin
      osr = $urandom;
      // Masked random never selects the sensor channel
      ch = (m % 3 == 0) ? 8'h0f : $urandom & 8'hee;
      wr(8, m[3]);
      wr(3, ch);
      wr(0, {m[0], m[1], m[2], osr, 1'b0, osr[0]});
      pw = !m[2];
      bg = m[3] | pw;
      md = pw & !m[1];
      chk({bandgap_en, cm_ref_en, regulator_on}, {bg, bg, m[3]});
      chk({amp_en, filter_en, modulator_en}, {pw, pw, md});
      chk(filter_in_reset, md & m[0]);
      chk({neg_ch, pos_ch}, ch);
      chk(temp_sensor_en, md & (m % 3 == 0));
      chk({oversampling_rate_select, reference_pair_select},
        {osr, osr[0]});
    end
    for (int j = 0; j < 3; j++) begin
      res[4:0] = (j == 2) ? 5'h1f : $urandom % 7;
      wr(2, res[4:0]);
      tick_gap(res[4:0]);
    end
    wr(8, 1);
    wr(2, 8'h1f);
    wr(1, 8'hc0);
    wr(3, 0);
    wr(7, 3);
    // power and sleep cleared before the pulse
    wr(0, 8'h1c);
    // filter reset high then low starts conversion
    wr(0, 8'h9c);
    wr(0, 8'h1c);
    chk(chop_clock_select, 3'b110);
    wait_done;
    chk(n * 2 >= 1530, 1);
    chk(conv_irq, 1);
    rd_res(res);
    chk(res, 24'h7f_ffff);
    wr(7, 1);
    wr(1, 8'hc2);
    rd(1, d);
    chk(d[1], 1);
    wr(1, 8'hc4);
    pattern <= 0;
    repeat (4000) @(posedge core_clk);
    rd(1, d);
    chk(d[1], 0);
    rd(7, d);
    chk(d[2], 0);
    rd_res(res);
    chk(res, 24'h7f_ffff);
    wr(1, 8'hc0);
    wait_done;
    wr(1, 8'hc0);
    wait_done;
    rd_res(res);
    chk(res, 24'h80_0000);
    rd(7, d);
    chk({d[2], conv_irq}, 2'b10);
    repeat (1700) @(posedge core_clk);
    rd(1, d);
    chk(d[1], 1);
    // Writing one to the request bit keeps it
    wr(7, 8'h07);
    chk(conv_irq, 1);
    wr(7, 8'h03);
    chk(conv_irq, 0);
    test_done();
  end
endmodule
`default_nettype wire
